// >>> core/sld_pkg.sv
package sld_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ             = 100000000;
  localparam int unsigned CYC_PER_MS         = CLK_HZ / 1000;
  localparam int unsigned STRETCH_NORMAL_MS  = 40;
  localparam int unsigned STRETCH_MEDIUM_MS  = 70;
  localparam int unsigned STRETCH_LONG_MS    = 140;
  localparam int unsigned BLINK_FAST_MS      = 50;
  localparam int unsigned BLINK_SLOW_MS      = 250;
  localparam int unsigned STRETCH_NORMAL_CYC = STRETCH_NORMAL_MS * CYC_PER_MS;
  localparam int unsigned STRETCH_MEDIUM_CYC = STRETCH_MEDIUM_MS * CYC_PER_MS;
  localparam int unsigned STRETCH_LONG_CYC   = STRETCH_LONG_MS * CYC_PER_MS;
  localparam int unsigned BLINK_FAST_CYC     = BLINK_FAST_MS * CYC_PER_MS;
  localparam int unsigned BLINK_SLOW_CYC     = BLINK_SLOW_MS * CYC_PER_MS;
  localparam int unsigned CNT_W              = 24;
  // the slow blink half period needs one bit more than the stretch count
  localparam int unsigned BLINK_W            = 25;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_CONFIG  = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h1;
  localparam logic [15:0] CONFIG_RESET = 16'h3422;
  localparam int unsigned FIRST_SEL_LSB  = 8;
  localparam int unsigned SECOND_SEL_LSB = 4;
  localparam int unsigned LEN_SEL_LSB    = 2;
  localparam int unsigned STRETCH_EN_BIT = 1;

  // ----------------------------------------------------------------
  // selection codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_TX        = 4'h1;
  localparam logic [3:0] SEL_RX        = 4'h2;
  localparam logic [3:0] SEL_COL       = 4'h3;
  localparam logic [3:0] SEL_LINK      = 4'h4;
  localparam logic [3:0] SEL_DUPLEX    = 4'h5;
  localparam logic [3:0] SEL_TXRX      = 4'h7;
  localparam logic [3:0] SEL_ON        = 4'h8;
  localparam logic [3:0] SEL_OFF       = 4'h9;
  localparam logic [3:0] SEL_FAST      = 4'hA;
  localparam logic [3:0] SEL_SLOW      = 4'hB;
  localparam logic [3:0] SEL_LINK_RX   = 4'hC;
  localparam logic [3:0] SEL_LINK_TXRX = 4'hD;
  localparam logic [3:0] SEL_DPX_COL   = 4'hE;

  localparam logic [1:0] LEN_NORMAL = 2'h0;
  localparam logic [1:0] LEN_MEDIUM = 2'h1;
  localparam logic [1:0] LEN_LONG   = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SLD_SENSE = 1'b0,
    SLD_RUN   = 1'b1
  } sld_mode_t;

  typedef struct packed {
    logic link_up;
    logic full_duplex;
    logic tx_act;
    logic rx_act;
    logic col_act;
  } sld_phy_stat_t;

  typedef struct packed {
    logic first_in;
    logic second_in;
  } sld_pin_in_t;

  typedef struct packed {
    logic first_out;
    logic first_oe;
    logic second_out;
    logic second_oe;
  } sld_pin_out_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } sld_stretch_st_t;

  typedef struct packed {
    logic [BLINK_W-1:0] count;
    logic               level;
  } sld_blink_st_t;

  typedef struct packed {
    sld_mode_t   mode;
    logic [15:0] cfg;
    logic [15:0] rdata;
    logic        sink_a;
    logic        sink_b;
    logic        pin_a;
    logic        pin_b;
    logic        oe;
    logic        duplex;
  } sld_top_st_t;

endpackage

// >>> core/sld_blink.sv
`timescale 1ns/1ns
`default_nettype none
module sld_blink #(
  parameter logic [24:0] HALF_CYC = 25'h00F4240
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // pattern
  output logic      level_o
);

  sld_pkg::sld_blink_st_t q;
  sld_pkg::sld_blink_st_t next_q;

  always_comb begin
    next_q = q;
    if (q.count >= HALF_CYC - 25'h0000001) begin
      next_q.count = 25'h0000000;
      next_q.level = ~q.level;
    end else begin
      next_q.count = q.count + 25'h0000001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level_o = q.level;

endmodule
`default_nettype wire

// >>> core/sld_stretch.sv
`timescale 1ns/1ns
`default_nettype none
module sld_stretch #(
  parameter logic [23:0] NORMAL_CYC = 24'h3D0900,
  parameter logic [23:0] MEDIUM_CYC = 24'h6ACFC0,
  parameter logic [23:0] LONG_CYC   = 24'hD59F80
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // event and length
  input  wire logic       event_i,
  input  wire logic [1:0] len_sel_i,
  output logic            active_o
);

  sld_pkg::sld_stretch_st_t q;
  sld_pkg::sld_stretch_st_t next_q;
  logic [23:0]              load;

  always_comb begin
    next_q = q;
    if (len_sel_i == sld_pkg::LEN_LONG) begin
      load = LONG_CYC;
    end else if (len_sel_i == sld_pkg::LEN_MEDIUM) begin
      load = MEDIUM_CYC;
    end else begin
      load = NORMAL_CYC;
    end
    if (event_i) begin
      next_q.count = load;
    end else if (q.count != 24'h000000) begin
      next_q.count = q.count - 24'h000001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign active_o = event_i | (q.count != 24'h000000);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_normal_length: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (event_i && len_sel_i == sld_pkg::LEN_NORMAL)
      |=> (q.count == NORMAL_CYC) && active_o)
    else $error("normal stretch not loaded");

  a_medium_length: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (event_i && len_sel_i == sld_pkg::LEN_MEDIUM)
      |=> (q.count == MEDIUM_CYC) && active_o)
    else $error("medium stretch not loaded");

  a_long_length: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (event_i && len_sel_i == sld_pkg::LEN_LONG)
      |=> (q.count == LONG_CYC) && active_o)
    else $error("long stretch not loaded");

  a_restart_timer: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.count != 24'h000000 && !event_i) ##1 event_i
      |=> (q.count == $past(load)))
    else $error("stretch not restarted");

endmodule
`default_nettype wire

// >>> core/sld_top.sv
// Functional notes
// - The normal stretch length holds a stretched event for 40 ms.
// - The medium stretch length holds a stretched event for 70 ms.
// - The long stretch length holds a stretched event for 140 ms.
// - Code 1010 blinks the indicator fast and code 1001 keeps it off.
// - Code 0111 shows tx or rx activity, stretched if enabled; 0110 is off.
// - After reset each pin's wiring is sensed and drive polarity matched.
// - Wiring is sensed only once per reset, never while running.
// - The duplex default is half when the second pin sources, else full.
`timescale 1ns/1ns
`default_nettype none
module sld_top #(
  parameter logic [23:0] STRETCH_NORMAL_CYC =
    24'(sld_pkg::STRETCH_NORMAL_CYC),
  parameter logic [23:0] STRETCH_MEDIUM_CYC =
    24'(sld_pkg::STRETCH_MEDIUM_CYC),
  parameter logic [23:0] STRETCH_LONG_CYC   =
    24'(sld_pkg::STRETCH_LONG_CYC),
  parameter logic [24:0] BLINK_FAST_CYC     =
    25'(sld_pkg::BLINK_FAST_CYC),
  parameter logic [24:0] BLINK_SLOW_CYC     =
    25'(sld_pkg::BLINK_SLOW_CYC)
) (
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // register port
  input  wire logic [3:0]             addr_i,
  input  wire logic [15:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [15:0]            rdata_o,
  // phy status
  input  wire sld_pkg::sld_phy_stat_t phy_stat_i,
  // indicator pins
  input  wire sld_pkg::sld_pin_in_t   pins_i,
  output sld_pkg::sld_pin_out_t       pins_o,
  // duplex default towards the phy
  output logic                        phy_duplex_default_o
);

  sld_pkg::sld_top_st_t q;
  sld_pkg::sld_top_st_t next_q;

  logic [3:0] first_led_select;
  logic [3:0] second_led_select;
  logic [1:0] stretch_length_select;
  logic       stretch_en;
  logic       s_tx;
  logic       s_rx;
  logic       s_col;
  logic       blink_fast;
  logic       blink_slow;
  logic       act_a;
  logic       act_b;

  assign first_led_select      = q.cfg[sld_pkg::FIRST_SEL_LSB +: 4];
  assign second_led_select     = q.cfg[sld_pkg::SECOND_SEL_LSB +: 4];
  assign stretch_length_select = q.cfg[sld_pkg::LEN_SEL_LSB +: 2];
  assign stretch_en            = q.cfg[sld_pkg::STRETCH_EN_BIT];

  // ----------------------------------------------------------------
  // event stretchers and blink patterns
  // ----------------------------------------------------------------
  sld_stretch #(
    .NORMAL_CYC (STRETCH_NORMAL_CYC),
    .MEDIUM_CYC (STRETCH_MEDIUM_CYC),
    .LONG_CYC   (STRETCH_LONG_CYC)
  ) u_str_tx (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .event_i   (phy_stat_i.tx_act),
    .len_sel_i (stretch_length_select),
    .active_o  (s_tx)
  );

  sld_stretch #(
    .NORMAL_CYC (STRETCH_NORMAL_CYC),
    .MEDIUM_CYC (STRETCH_MEDIUM_CYC),
    .LONG_CYC   (STRETCH_LONG_CYC)
  ) u_str_rx (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .event_i   (phy_stat_i.rx_act),
    .len_sel_i (stretch_length_select),
    .active_o  (s_rx)
  );

  sld_stretch #(
    .NORMAL_CYC (STRETCH_NORMAL_CYC),
    .MEDIUM_CYC (STRETCH_MEDIUM_CYC),
    .LONG_CYC   (STRETCH_LONG_CYC)
  ) u_str_col (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .event_i   (phy_stat_i.col_act),
    .len_sel_i (stretch_length_select),
    .active_o  (s_col)
  );

  sld_blink #(.HALF_CYC(BLINK_FAST_CYC)) u_blink_fast (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .level_o   (blink_fast)
  );

  sld_blink #(.HALF_CYC(BLINK_SLOW_CYC)) u_blink_slow (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .level_o   (blink_slow)
  );

  // ----------------------------------------------------------------
  // display selection
  // ----------------------------------------------------------------
  function automatic logic led_active(input logic [3:0] sel);
    logic tx;
    logic rx;
    logic col;
    logic txrx;
    tx   = stretch_en ? s_tx : phy_stat_i.tx_act;
    rx   = stretch_en ? s_rx : phy_stat_i.rx_act;
    col  = stretch_en ? s_col : phy_stat_i.col_act;
    txrx = stretch_en ? (s_tx | s_rx)
                      : (phy_stat_i.tx_act | phy_stat_i.rx_act);
    case (sel)
      sld_pkg::SEL_TX:        led_active = tx;
      sld_pkg::SEL_RX:        led_active = rx;
      sld_pkg::SEL_COL:       led_active = col;
      sld_pkg::SEL_LINK:      led_active = phy_stat_i.link_up;
      sld_pkg::SEL_DUPLEX:    led_active = phy_stat_i.full_duplex;
      sld_pkg::SEL_TXRX:      led_active = txrx;
      sld_pkg::SEL_ON:        led_active = 1'b1;
      sld_pkg::SEL_OFF:       led_active = 1'b0;
      sld_pkg::SEL_FAST:      led_active = blink_fast;
      sld_pkg::SEL_SLOW:      led_active = blink_slow;
      sld_pkg::SEL_LINK_RX:   led_active = phy_stat_i.link_up & ~s_rx;
      sld_pkg::SEL_LINK_TXRX: led_active = phy_stat_i.link_up &
                                           ~(s_tx | s_rx);
      sld_pkg::SEL_DPX_COL:   led_active = phy_stat_i.full_duplex ^ s_col;
      default:                led_active = 1'b0; // reserved, incl. 0110
    endcase
    return led_active;
  endfunction

  // a process, so that the status inputs read inside the function wake it
  always_comb begin
    act_a = led_active(first_led_select);
    act_b = led_active(second_led_select);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    case (q.mode)
      sld_pkg::SLD_SENSE: begin
        // undriven pin is pulled high by an led wired to the supply
        next_q.sink_a = pins_i.first_in;
        next_q.sink_b = pins_i.second_in;
        next_q.duplex = pins_i.second_in;
        next_q.pin_a  = pins_i.first_in;
        next_q.pin_b  = pins_i.second_in;
        next_q.oe     = 1'b1;
        next_q.mode   = sld_pkg::SLD_RUN;
      end
      sld_pkg::SLD_RUN: begin
        // polarity stays frozen until the next reset
        next_q.pin_a = act_a ^ q.sink_a;
        next_q.pin_b = act_b ^ q.sink_b;
      end
      default: begin
        next_q.mode = sld_pkg::SLD_SENSE;
      end
    endcase
    if (wr_i && addr_i == sld_pkg::ADDR_CONFIG) begin
      next_q.cfg = wdata_i;
    end
    next_q.rdata = 16'h0000;
    if (rd_i && addr_i == sld_pkg::ADDR_CONFIG) begin
      next_q.rdata = q.cfg;
    end else if (rd_i && addr_i == sld_pkg::ADDR_STATUS) begin
      next_q.rdata = {11'h000, q.mode == sld_pkg::SLD_RUN,
                      q.pin_b ^ q.sink_b, q.pin_a ^ q.sink_a,
                      q.sink_b, q.sink_a};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q      <= '0;
      q.cfg  <= sld_pkg::CONFIG_RESET;
      q.mode <= sld_pkg::SLD_SENSE;
    end else begin
      q <= next_q;
    end
  end

  assign rdata_o              = q.rdata;
  assign pins_o.first_out     = q.pin_a;
  assign pins_o.first_oe      = q.oe;
  assign pins_o.second_out    = q.pin_b;
  assign pins_o.second_oe     = q.oe;
  assign phy_duplex_default_o = q.duplex;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_sensing;
    q.mode == sld_pkg::SLD_SENSE && !q.oe;
  endsequence

  sequence s_sensed;
    q.mode == sld_pkg::SLD_RUN && q.oe &&
    q.sink_a == $past(pins_i.first_in) &&
    q.sink_b == $past(pins_i.second_in);
  endsequence

  a_sense_wiring: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_sensing |=> s_sensed)
    else $error("wiring not sensed after reset");

  a_polarity_frozen: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.mode == sld_pkg::SLD_RUN)
      |=> (q.mode == sld_pkg::SLD_RUN) &&
          $stable(q.sink_a) && $stable(q.sink_b))
    else $error("polarity changed while running");

  a_duplex_default: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_sensing |=> (phy_duplex_default_o == $past(pins_i.second_in))
      ##1 $stable(phy_duplex_default_o))
    else $error("duplex default does not follow second pin");

  a_off_code: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.mode == sld_pkg::SLD_RUN && first_led_select == sld_pkg::SEL_OFF)
      |=> (pins_o.first_out == q.sink_a))
    else $error("off code drives led on");

  a_fast_blink: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.mode == sld_pkg::SLD_RUN && first_led_select == sld_pkg::SEL_FAST)
      |=> (pins_o.first_out == ($past(blink_fast) ^ q.sink_a)))
    else $error("fast blink not shown");

  a_txrx_stretch: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.mode == sld_pkg::SLD_RUN && stretch_en &&
     first_led_select == sld_pkg::SEL_TXRX)
      |=> (pins_o.first_out == ($past(s_tx | s_rx) ^ q.sink_a)))
    else $error("tx rx activity not shown");

  a_reserved_dark: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.mode == sld_pkg::SLD_RUN && first_led_select == 4'h6)
      |=> (pins_o.first_out == q.sink_a))
    else $error("reserved code lights led");

  a_run_drives: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.mode == sld_pkg::SLD_RUN) |-> q.oe)
    else $error("pins not driven while running");

  a_on_code: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.mode == sld_pkg::SLD_RUN && first_led_select == sld_pkg::SEL_ON)
      |=> (pins_o.first_out != q.sink_a))
    else $error("on code leaves led dark");

  a_link_shown: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.mode == sld_pkg::SLD_RUN && first_led_select == sld_pkg::SEL_LINK)
      |=> (pins_o.first_out == ($past(phy_stat_i.link_up) ^ q.sink_a)))
    else $error("link status not shown");

  a_txrx_direct: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.mode == sld_pkg::SLD_RUN && !stretch_en &&
     first_led_select == sld_pkg::SEL_TXRX)
      |=> (pins_o.first_out ==
           ($past(phy_stat_i.tx_act | phy_stat_i.rx_act) ^ q.sink_a)))
    else $error("unstretched activity not shown");

  a_second_off: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (q.mode == sld_pkg::SLD_RUN && second_led_select == sld_pkg::SEL_OFF)
      |=> (pins_o.second_out == q.sink_b))
    else $error("second off code drives led on");

  a_config_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == sld_pkg::ADDR_CONFIG) |=> (q.cfg == $past(wdata_i)))
    else $error("config write lost");

  a_config_read: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == sld_pkg::ADDR_CONFIG) |=> (rdata_o == $past(q.cfg)))
    else $error("config read data wrong");

  a_read_idle: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !rd_i |=> (rdata_o == 16'h0000))
    else $error("read data not cleared");

endmodule
`default_nettype wire

// >>> dv/sld_led_board.sv
`timescale 1ns/1ns
`default_nettype none
module sld_led_board (
  // wiring straps: 1 = led tied to supply, pin sinks
  input  wire logic                  sink_first_i,
  input  wire logic                  sink_second_i,
  // pins
  input  wire sld_pkg::sld_pin_out_t pin_drive_i,
  output sld_pkg::sld_pin_in_t       pin_level_o,
  // light seen on the board
  output logic                       lit_first_o,
  output logic                       lit_second_o
);
  // --------------------------------------------------------------
  // undriven pin is pulled through the led to its far rail
  // --------------------------------------------------------------
  always_comb begin
    pin_level_o.first_in  = pin_drive_i.first_oe ?
                            pin_drive_i.first_out : sink_first_i;
    pin_level_o.second_in = pin_drive_i.second_oe ?
                            pin_drive_i.second_out : sink_second_i;
    lit_first_o  = pin_drive_i.first_oe &
                   (pin_drive_i.first_out ^ sink_first_i);
    lit_second_o = pin_drive_i.second_oe &
                   (pin_drive_i.second_out ^ sink_second_i);
  end
endmodule
`default_nettype wire

// >>> dv/sld_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sld_top_tb;
  localparam int unsigned NRM = 20;
  localparam int unsigned MED = 35;
  localparam int unsigned LNG = 70;
  logic                   ref_clk_i = 1'b0;
  logic                   rst_n_i   = 1'b0;
  logic [3:0]             addr_i    = 4'h0;
  logic [15:0]            wdata_i   = 16'h0000;
  logic                   wr_i      = 1'b0;
  logic                   rd_i      = 1'b0;
  logic [15:0]            rdata_o;
  sld_pkg::sld_phy_stat_t phy_stat_i = '0;
  sld_pkg::sld_pin_in_t   pins_i;
  sld_pkg::sld_pin_out_t  pins_o;
  logic                   phy_duplex_default_o;
  logic                   sink_a    = 1'b0;
  logic                   sink_b    = 1'b1;
  logic                   lit_a;
  logic                   lit_b;
  int                     err_count = 0;
  int                     total_checks = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  sld_top #(
    .STRETCH_NORMAL_CYC(24'h000014),
    .STRETCH_MEDIUM_CYC(24'h000023),
    .STRETCH_LONG_CYC  (24'h000046),
    .BLINK_FAST_CYC    (25'h0000004),
    .BLINK_SLOW_CYC    (25'h0000008)
  ) DUT (
    .ref_clk_i           (ref_clk_i),
    .rst_n_i             (rst_n_i),
    .addr_i              (addr_i),
    .wdata_i             (wdata_i),
    .wr_i                (wr_i),
    .rd_i                (rd_i),
    .rdata_o             (rdata_o),
    .phy_stat_i          (phy_stat_i),
    .pins_i              (pins_i),
    .pins_o              (pins_o),
    .phy_duplex_default_o(phy_duplex_default_o)
  );

  sld_led_board board (
    .sink_first_i (sink_a),
    .sink_second_i(sink_b),
    .pin_drive_i  (pins_o),
    .pin_level_o  (pins_i),
    .lit_first_o  (lit_a),
    .lit_second_o (lit_b)
  );

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      $display("unexpected at %0t: %s", $time, msg);
      err_count++;
    end
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  // first select, stretch length and enable; second led kept off
  function automatic logic [15:0] cfg(logic [3:0] f, logic [1:0] len,
                                      logic en);
    return {4'h0, f, sld_pkg::SEL_OFF, len, en, 1'b0};
  endfunction

  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    step(2);
  endtask

  task automatic set_act(input logic t, input logic r);
    @(posedge ref_clk_i);
    phy_stat_i.tx_act <= t;
    phy_stat_i.rx_act <= r;
    step(2);
  endtask

  task automatic pulse_tx;
    @(posedge ref_clk_i);
    phy_stat_i.tx_act <= 1'b1;
    @(posedge ref_clk_i);
    phy_stat_i.tx_act <= 1'b0;
    #1;
  endtask

  // cycles for which the first led keeps lit, bounded
  task automatic count_lit(output int n);
    n = 0;
    while (lit_a === 1'b1 && n < 300) begin
      n++;
      step(1);
    end
    if (n == 300) begin
      chk(1'b0, "stretch never ends");
      test_done;
    end
  endtask

  task automatic blink_half(input int half, input string msg);
    logic prev;
    int   n;
    step(3);
    for (int k = 0; k < 2; k++) begin
      prev = lit_a;
      n = 0;
      while (lit_a === prev && n < 40) begin
        step(1);
        n++;
      end
    end
    chk(n == half, msg);
    if (n == 40) begin
      test_done;
    end
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs;
    logic [15:0] d;
    rd_reg(sld_pkg::ADDR_CONFIG, d);
    chk(d === 16'h3422, "config reset value");
    rd_reg(sld_pkg::ADDR_STATUS, d);
    chk(d[1:0] === {sink_b, sink_a}, "sensed wiring");
    chk(d[4] === 1'b1, "running flag");
    chk(phy_duplex_default_o === sink_b, "duplex default");
    wr_reg(4'h5, 16'hFFFF);
    wr_reg(sld_pkg::ADDR_STATUS, 16'hFFFF);
    rd_reg(4'h5, d);
    chk(d === 16'h0000, "unmapped read");
    rd_reg(sld_pkg::ADDR_CONFIG, d);
    chk(d === 16'h3422, "config hit by stray write");
    wr_reg(sld_pkg::ADDR_CONFIG, 16'hF9AF);
    rd_reg(sld_pkg::ADDR_CONFIG, d);
    chk(d === 16'hF9AF, "config readback");
    $display("test regs done");
  endtask

  task automatic t_codes;
    wr_reg(sld_pkg::ADDR_CONFIG,
           {4'h0, sld_pkg::SEL_OFF, sld_pkg::SEL_ON, 4'h0});
    step(3);
    chk(lit_b === 1'b1, "second on code dark");
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_ON, 2'h0, 1'b0));
    set_act(1'b1, 1'b1);
    chk(lit_a === 1'b1, "on code dark");
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_OFF, 2'h0, 1'b0));
    step(3);
    chk(lit_a === 1'b0, "off code lit");
    chk(lit_b === 1'b0, "second off code lit");
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(4'h6, 2'h0, 1'b0));
    step(3);
    chk(lit_a === 1'b0, "reserved code lit");
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_TXRX, 2'h0, 1'b0));
    set_act(1'b0, 1'b1);
    chk(lit_a === 1'b1, "rx not shown");
    set_act(1'b1, 1'b0);
    chk(lit_a === 1'b1, "tx not shown");
    set_act(1'b0, 1'b0);
    chk(lit_a === 1'b0, "unstretched activity held");
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_FAST, 2'h0, 1'b0));
    blink_half(4, "fast blink rate");
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_SLOW, 2'h0, 1'b0));
    blink_half(8, "slow blink rate");
    $display("test codes done");
  endtask

  task automatic t_stretch;
    int lens [4];
    int n;
    lens = '{NRM, MED, LNG, NRM};
    for (int i = 0; i < 4; i++) begin
      wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_TX, 2'(i), 1'b1));
      step(3);
      pulse_tx;
      count_lit(n);
      chk(n >= lens[i] && n <= lens[i] + 2, "stretch");
    end
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_TXRX, 2'h0, 1'b1));
    step(3);
    pulse_tx;
    count_lit(n);
    chk(n >= NRM && n <= NRM + 2, "combined stretch");
    $display("test stretch done");
  endtask

  task automatic t_restart;
    int n;
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_TX, 2'h0, 1'b1));
    step(3);
    pulse_tx;
    step(10);
    pulse_tx;
    count_lit(n);
    chk(n >= NRM && n <= NRM + 2, "stretch not restarted");
    $display("test restart done");
  endtask

  task automatic t_status;
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_DUPLEX, 2'h0, 1'b0));
    step(3);
    chk(lit_a === 1'b0, "half duplex lit");
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_LINK, 2'h0, 1'b0));
    step(3);
    chk(lit_a === 1'b0, "link shown while down");
    @(posedge ref_clk_i);
    phy_stat_i.link_up <= 1'b1;
    step(2);
    chk(lit_a === 1'b1, "link not shown");
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_LINK_RX, 2'h0, 1'b0));
    step(3);
    chk(lit_a === 1'b1, "link dark without rx");
    set_act(1'b0, 1'b1);
    chk(lit_a === 1'b0, "rx does not blip link");
    set_act(1'b0, 1'b0);
    $display("test status done");
  endtask

  task automatic t_rewire;
    logic [15:0] d;
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_ON, 2'h0, 1'b0));
    step(3);
    sink_a = 1'b1;
    sink_b = 1'b0;
    step(3);
    rd_reg(sld_pkg::ADDR_STATUS, d);
    chk(d[1:0] === 2'b10, "wiring resensed while running");
    chk(lit_a === 1'b0, "polarity changed while running");
    chk(phy_duplex_default_o === 1'b1, "duplex moved");
    do_reset;
    rd_reg(sld_pkg::ADDR_STATUS, d);
    chk(d[1:0] === 2'b01, "new wiring not sensed");
    chk(phy_duplex_default_o === 1'b0, "half duplex default");
    wr_reg(sld_pkg::ADDR_CONFIG, cfg(sld_pkg::SEL_ON, 2'h0, 1'b0));
    step(3);
    chk(lit_a === 1'b1, "sink led dark");
    $display("test rewire done");
  endtask

  initial begin
    do_reset;
    t_regs;
    t_codes;
    t_stretch;
    t_restart;
    t_status;
    t_rewire;
    test_done;
  end
endmodule
`default_nettype wire
